// ==== hdl/vbi_output_and_video_status.sv ====
// output control and status registers for sliced vbi and video lock
// assumes all inputs come from decoder logic on CORE_CLK, field start
// is a one-cycle pulse and FIELD_ODD gives the parity of the new field
//
// Notes on behaviour
// - bit 7 inserts sliced captions as ancillary data when sliced
// - bit 6 inserts aspect signalling as ancillary data when sliced
// - caption and aspect results reach the host regardless of output enables
// - bit 5 inserts sliced teletext into the stream as ancillary data
// - teletext content has no host read path, ancillary output only
// - bit 0 enables realtime control info; bits 4 to 1 reserved, zero
// - status flags are read only; host writes to them are discarded
// - detection bit 7 marks captions in odd field, bit 6 even field
// - detection bit 5 marks aspect data odd field, bit 4 even field
// - detection bit 3 marks teletext in blanking; bits 2 to 0 zero
// - video status bit 7 shows vertical lock
// - video status bit 6 shows horizontal lock
// - video status bit 5 shows colour subcarrier lock
// - video status bit 4 shows video present at selected input
// - bits 3 to 1 report copy protection detect state codes
// - bit 0 shows standard identified, only with auto detection enabled
// - two-bit slicer field selects none, odd, even or both fields
`timescale 1ns/100ps
`default_nettype none

module vbi_output_and_video_status (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic [1:0] SLICE_CAPTION_MODE,
   input wire logic [1:0] SLICE_ASPECT_MODE,
   input wire logic AUTO_DETECT_EN,
   input wire logic FIELD_START,
   input wire logic FIELD_ODD,
   input wire logic CAPTION_FOUND,
   input wire logic ASPECT_FOUND,
   input wire logic TELETEXT_FOUND,
   input wire logic [7:0] TELETEXT_DATA,
   input wire logic V_LOCK,
   input wire logic H_LOCK,
   input wire logic CHROMA_LOCK,
   input wire logic VIDEO_PRESENT,
   input wire logic [2:0] COPY_PROTECT_STATE,
   input wire logic STD_FOUND,
   output logic CAPTION_SERVICE_ANC_EN,
   output logic ASPECT_SERVICE_ANC_EN,
   output logic TELETEXT_ANC_EN,
   output logic REALTIME_CONTROL_INFO_ANC_EN,
   output logic [7:0] ANC_TELETEXT_DATA,
   output logic CAPTION_HOST_LATCH,
   output logic ASPECT_HOST_LATCH
);

   logic [7:0] out_ctrl_q;
   logic [7:0] detect_q;
   logic [7:0] vstat_q;
   logic [7:0] rdata_d;
   logic field_odd_q;
   logic cap_seen_q;
   logic asp_seen_q;
   logic ttx_seen_q;
   logic cap_seen_d;
   logic asp_seen_d;
   logic ttx_seen_d;
   logic cap_slice;
   logic asp_slice;
   logic [2:0] cp_code;

   // slicer selection for the field now in progress
   assign cap_slice = vbi_status_pkg::slice_hits(SLICE_CAPTION_MODE,
                                                 field_odd_q);
   assign asp_slice = vbi_status_pkg::slice_hits(SLICE_ASPECT_MODE,
                                                 field_odd_q);

   // only enable bits are stored, reserved bits stay zero
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         out_ctrl_q <= vbi_status_pkg::REG_RESET;
      end else if (REG_WR && REG_ADDR == vbi_status_pkg::OUT_CTRL_ADDR) begin
         out_ctrl_q <= REG_WDATA & vbi_status_pkg::OUT_CTRL_WMASK;
      end
   end

   // parity of the field in progress
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         field_odd_q <= 1'b0;
      end else if (FIELD_START) begin
         field_odd_q <= FIELD_ODD;
      end
   end

   // hits in the cycle of field start still belong to the ending field
   always_comb begin
      cap_seen_d = cap_seen_q | CAPTION_FOUND;
      asp_seen_d = asp_seen_q | ASPECT_FOUND;
      ttx_seen_d = ttx_seen_q | TELETEXT_FOUND;
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         cap_seen_q <= 1'b0;
         asp_seen_q <= 1'b0;
         ttx_seen_q <= 1'b0;
      end else if (FIELD_START) begin
         cap_seen_q <= 1'b0;
         asp_seen_q <= 1'b0;
         ttx_seen_q <= 1'b0;
      end else begin
         cap_seen_q <= cap_seen_d;
         asp_seen_q <= asp_seen_d;
         ttx_seen_q <= ttx_seen_d;
      end
   end

   // commit at each field start; host writes never reach these bits
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         detect_q <= vbi_status_pkg::REG_RESET;
      end else if (FIELD_START) begin
         if (field_odd_q) begin
            detect_q[vbi_status_pkg::DF_CAP_ODD_BIT] <= cap_seen_d;
            detect_q[vbi_status_pkg::DF_ASP_ODD_BIT] <= asp_seen_d;
         end else begin
            detect_q[vbi_status_pkg::DF_CAP_EVEN_BIT] <=
               cap_seen_d;
            detect_q[vbi_status_pkg::DF_ASP_EVEN_BIT] <=
               asp_seen_d;
         end
         detect_q[vbi_status_pkg::DF_TTX_BIT] <= ttx_seen_d;
      end
   end

   // reserved copy protection codes reported as none
   assign cp_code = (COPY_PROTECT_STATE == vbi_status_pkg::CP_RSVD_A ||
                     COPY_PROTECT_STATE == vbi_status_pkg::CP_RSVD_B) ?
                    vbi_status_pkg::CP_NONE : COPY_PROTECT_STATE;

   // live snapshot, one cycle behind the core
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         vstat_q <= vbi_status_pkg::REG_RESET;
      end else begin
         vstat_q[vbi_status_pkg::VS_VLOCK_BIT] <= V_LOCK;
         vstat_q[vbi_status_pkg::VS_HLOCK_BIT] <= H_LOCK;
         vstat_q[vbi_status_pkg::VS_CLOCK_BIT] <= CHROMA_LOCK;
         vstat_q[vbi_status_pkg::VS_VIDEO_BIT] <= VIDEO_PRESENT;
         vstat_q[vbi_status_pkg::VS_CP_LSB +: 3] <= cp_code;
         vstat_q[vbi_status_pkg::VS_STD_BIT] <= STD_FOUND &
                                                AUTO_DETECT_EN;
      end
   end

   // teletext data has no sub-address: unmapped reads give zero
   always_comb begin
      unique case (REG_ADDR)
         vbi_status_pkg::OUT_CTRL_ADDR: rdata_d = out_ctrl_q;
         vbi_status_pkg::DETECT_ADDR: rdata_d = detect_q;
         vbi_status_pkg::VSTAT_ADDR: rdata_d = vstat_q;
         default: rdata_d = vbi_status_pkg::REG_RESET;
      endcase
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         REG_RDATA <= vbi_status_pkg::REG_RESET;
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_RD;
         if (REG_RD) begin
            REG_RDATA <= rdata_d;
         end
      end
   end

   // ancillary insertion enables
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         CAPTION_SERVICE_ANC_EN <= 1'b0;
         ASPECT_SERVICE_ANC_EN <= 1'b0;
         TELETEXT_ANC_EN <= 1'b0;
         REALTIME_CONTROL_INFO_ANC_EN <= 1'b0;
      end else begin
         CAPTION_SERVICE_ANC_EN <= out_ctrl_q[vbi_status_pkg::OC_CAPTION_BIT] &
                                   cap_slice;
         ASPECT_SERVICE_ANC_EN <= out_ctrl_q[vbi_status_pkg::OC_ASPECT_BIT] &
                                  asp_slice;
         TELETEXT_ANC_EN <= out_ctrl_q[vbi_status_pkg::OC_TELETEXT_BIT];
         REALTIME_CONTROL_INFO_ANC_EN <=
            out_ctrl_q[vbi_status_pkg::OC_REALTIME_BIT];
      end
   end

   // teletext bytes only leave toward the ancillary inserter
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ANC_TELETEXT_DATA <= vbi_status_pkg::REG_RESET;
      end else begin
         ANC_TELETEXT_DATA <= out_ctrl_q[vbi_status_pkg::OC_TELETEXT_BIT] ?
                              TELETEXT_DATA : 8'h00;
      end
   end

   // host result latches ignore the output enables on purpose
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         CAPTION_HOST_LATCH <= 1'b0;
         ASPECT_HOST_LATCH <= 1'b0;
      end else begin
         CAPTION_HOST_LATCH <= CAPTION_FOUND & cap_slice;
         ASPECT_HOST_LATCH <= ASPECT_FOUND & asp_slice;
      end
   end

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   sequence s_field_end_odd_hit;
      FIELD_START && field_odd_q && CAPTION_FOUND;
   endsequence

   sequence s_hit_then_end;
      CAPTION_FOUND && !FIELD_START && field_odd_q ##1
      (!FIELD_START && field_odd_q) [*2] ##1 FIELD_START;
   endsequence

   a_caption_anc_gate: assert property (
      CAPTION_SERVICE_ANC_EN ==
      $past(out_ctrl_q[7] && cap_slice))
      else $error("caption insertion enable wrong");

   a_aspect_anc_gate: assert property (
      ##1 ASPECT_SERVICE_ANC_EN == $past(out_ctrl_q[6] &&
      vbi_status_pkg::slice_hits(SLICE_ASPECT_MODE, field_odd_q)))
      else $error("aspect insertion enable wrong");

   a_host_latch_free: assert property (
      (CAPTION_FOUND && cap_slice && !out_ctrl_q[7]) |=>
      CAPTION_HOST_LATCH && !CAPTION_SERVICE_ANC_EN)
      else $error("caption host latch tied to output enable");

   a_teletext_write: assert property (
      (REG_WR && REG_ADDR == 8'h0b && REG_WDATA[5]) ##1
      !(REG_WR && REG_ADDR == 8'h0b) |=> TELETEXT_ANC_EN)
      else $error("teletext enable not taken");

   a_teletext_hidden: assert property (
      (REG_RD && REG_ADDR != 8'h0b && REG_ADDR != 8'h0c &&
       REG_ADDR != 8'h0e) |=> REG_RVALID && REG_RDATA == 8'h00)
      else $error("unmapped read not zero");

   a_reserved_ctrl: assert property (
      out_ctrl_q[4:1] == 4'h0)
      else $error("reserved control bits set");

   a_status_readonly: assert property (
      (!FIELD_START) |=> $stable(detect_q))
      else $error("detection flags changed outside field start");

   a_caption_odd_flag: assert property (
      s_hit_then_end |=> detect_q[7])
      else $error("odd caption flag not set");

   a_caption_odd_same: assert property (
      s_field_end_odd_hit |=> detect_q[7])
      else $error("caption hit lost at field start");

   a_aspect_even_flag: assert property (
      (FIELD_START && !field_odd_q && !ASPECT_FOUND && !asp_seen_q) |=>
      !detect_q[4])
      else $error("even aspect flag not cleared");

   a_teletext_flag: assert property (
      FIELD_START |=> detect_q[3] == $past(ttx_seen_q || TELETEXT_FOUND) &&
      detect_q[2:0] == 3'h0)
      else $error("teletext flag wrong");

   a_lock_bits: assert property (
      ##1 vstat_q[7:4] == $past({V_LOCK, H_LOCK, CHROMA_LOCK, VIDEO_PRESENT}))
      else $error("lock bits do not follow decoder");

   a_cp_code: assert property (
      vstat_q[3:1] != 3'h4 && vstat_q[3:1] != 3'h5)
      else $error("reserved copy protection code shown");

   a_std_gate: assert property (
      !AUTO_DETECT_EN |=> !vstat_q[0])
      else $error("standard flag without auto detection");

   a_slice_none: assert property (
      (SLICE_CAPTION_MODE == 2'h0) |=> !CAPTION_SERVICE_ANC_EN)
      else $error("captions inserted with slicing off");

   // a second write right behind would overwrite the first
   sequence s_ctrl_write_alone;
      REG_WR && REG_ADDR == vbi_status_pkg::OUT_CTRL_ADDR ##1
      !(REG_WR && REG_ADDR == vbi_status_pkg::OUT_CTRL_ADDR);
   endsequence

   a_realtime_enable: assert property (
      s_ctrl_write_alone |=> REALTIME_CONTROL_INFO_ANC_EN ==
      $past(REG_WDATA[vbi_status_pkg::OC_REALTIME_BIT], 2))
      else $error("realtime control enable not taken");

   a_caption_even_flag: assert property (
      (FIELD_START && !field_odd_q && CAPTION_FOUND) |=>
      detect_q[vbi_status_pkg::DF_CAP_EVEN_BIT])
      else $error("even caption hit lost at field start");

   a_aspect_latch: assert property (
      (ASPECT_FOUND && asp_slice) |=> ASPECT_HOST_LATCH)
      else $error("aspect host latch missed");

   a_rdata_hold: assert property (
      !REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without a read");

   a_rvalid_pulse: assert property (
      !REG_RD |=> !REG_RVALID)
      else $error("read answer without a read");

   a_ctrl_only_own: assert property (
      (REG_WR && REG_ADDR != vbi_status_pkg::OUT_CTRL_ADDR) |=>
      $stable(out_ctrl_q))
      else $error("control changed by a foreign write");

   a_ttx_anc_off: assert property (
      !out_ctrl_q[vbi_status_pkg::OC_TELETEXT_BIT] |=>
      ANC_TELETEXT_DATA == vbi_status_pkg::REG_RESET)
      else $error("teletext bytes leak while disabled");

   a_ttx_anc_pass: assert property (
      out_ctrl_q[vbi_status_pkg::OC_TELETEXT_BIT] |=>
      ANC_TELETEXT_DATA == $past(TELETEXT_DATA))
      else $error("teletext bytes not passed on");

   a_ctrl_read_rsvd: assert property (
      (REG_RD && REG_ADDR == vbi_status_pkg::OUT_CTRL_ADDR) |=>
      REG_RDATA[4:1] == 4'h0)
      else $error("reserved control bits read back set");

endmodule

`default_nettype wire

// ==== shared/vbi_status_pkg.sv ====
// constants for the vbi output control and video status registers
// assumes an 8-bit sub-address register port from the serial front end
package vbi_status_pkg;

   // sub-addresses
   localparam logic [7:0] OUT_CTRL_ADDR = 8'h0b;
   localparam logic [7:0] DETECT_ADDR = 8'h0c;
   localparam logic [7:0] VSTAT_ADDR = 8'h0e;

   // output control fields
   localparam int OC_CAPTION_BIT = 7;
   localparam int OC_ASPECT_BIT = 6;
   localparam int OC_TELETEXT_BIT = 5;
   localparam int OC_REALTIME_BIT = 0;
   localparam logic [7:0] OUT_CTRL_WMASK = 8'he1;

   // detection flag fields
   localparam int DF_CAP_ODD_BIT = 7;
   localparam int DF_CAP_EVEN_BIT = 6;
   localparam int DF_ASP_ODD_BIT = 5;
   localparam int DF_ASP_EVEN_BIT = 4;
   localparam int DF_TTX_BIT = 3;

   // video status fields
   localparam int VS_VLOCK_BIT = 7;
   localparam int VS_HLOCK_BIT = 6;
   localparam int VS_CLOCK_BIT = 5;
   localparam int VS_VIDEO_BIT = 4;
   localparam int VS_CP_LSB = 1;
   localparam int VS_STD_BIT = 0;

   // values after reset
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [2:0] CP_NONE = 3'h0;

   // copy protection codes that must not be reported
   localparam logic [2:0] CP_RSVD_A = 3'h4;
   localparam logic [2:0] CP_RSVD_B = 3'h5;

   // slicer field selection
   localparam logic [1:0] SLICE_NONE = 2'h0;
   localparam logic [1:0] SLICE_ODD = 2'h1;
   localparam logic [1:0] SLICE_EVEN = 2'h2;
   localparam logic [1:0] SLICE_BOTH = 2'h3;

   // does a slicer field selection cover a field of this parity
   function automatic logic slice_hits(input logic [1:0] mode,
                                       input logic odd);
      slice_hits = (mode == SLICE_BOTH) ||
                   (odd && mode == SLICE_ODD) ||
                   (!odd && mode == SLICE_EVEN);
   endfunction

endpackage

// ==== verification/vbi_output_and_video_status_tb.sv ====
// self-checking bench for the vbi output and video status registers
// assumes the block alone, driven at its ports on one 10 MHz clock
`timescale 1ns/100ps
`default_nettype none

module vbi_output_and_video_status_tb;
   logic clk, rst, wr, rd, fst, fodd, ccf, wsf, ttf, autod, stdf;
   logic rvalid, cap_en, ws_en, tt_en, rt_en, cap_lat, ws_lat;
   logic [7:0] addr, wdata, rdata, ttd, anc_ttd, ctrl, det;
   logic [1:0] cmode, amode;
   logic [3:0] lock;
   logic [2:0] cps;
   logic cur_odd, acc_cap, acc_ws, acc_tt;
   int failures = 0;
   int checks_done = 0;

   vbi_output_and_video_status vbi_output_and_video_status_i (
      .CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .SLICE_CAPTION_MODE(cmode), .SLICE_ASPECT_MODE(amode),
      .AUTO_DETECT_EN(autod), .FIELD_START(fst), .FIELD_ODD(fodd),
      .CAPTION_FOUND(ccf), .ASPECT_FOUND(wsf), .TELETEXT_FOUND(ttf),
      .TELETEXT_DATA(ttd), .V_LOCK(lock[3]), .H_LOCK(lock[2]),
      .CHROMA_LOCK(lock[1]), .VIDEO_PRESENT(lock[0]),
      .COPY_PROTECT_STATE(cps), .STD_FOUND(stdf),
      .CAPTION_SERVICE_ANC_EN(cap_en), .ASPECT_SERVICE_ANC_EN(ws_en),
      .TELETEXT_ANC_EN(tt_en), .REALTIME_CONTROL_INFO_ANC_EN(rt_en),
      .ANC_TELETEXT_DATA(anc_ttd), .CAPTION_HOST_LATCH(cap_lat),
      .ASPECT_HOST_LATCH(ws_lat)
   );

   function automatic logic hits(input logic [1:0] m, input logic odd);
      return m == 2'h3 || (odd && m == 2'h1) || (!odd && m == 2'h2);
   endfunction

   // hit pulses only where the slicer covers the field, as in use
   function automatic logic [2:0] hit3(input logic cap);
      return {(cap | 1'($urandom)) & hits(cmode, cur_odd),
              1'($urandom) & hits(amode, cur_odd), 1'($urandom)};
   endfunction

   // reserved copy protect codes are reported as none
   function automatic logic [7:0] vstat();
      logic [2:0] c;
      c = (cps == 3'h4 || cps == 3'h5) ? 3'h0 : cps;
      return {lock, c, stdf & autod};
   endfunction

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // answer comes on the same edge that takes the strobe
   task automatic rreg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rvalid", 8'h01, {7'h0, rvalid});
      chk("rdata", e, rdata);
   endtask

   // model commits the ending field, parity from the previous start
   // hits in the start cycle still count for the ending field
   task automatic fs(input logic odd, input logic [2:0] h);
      @(posedge clk);
      fst <= 1'b1;
      fodd <= odd;
      {ccf, wsf, ttf} <= h;
      @(posedge clk);
      fst <= 1'b0;
      {ccf, wsf, ttf} <= 3'h0;
      {acc_cap, acc_ws, acc_tt} = {acc_cap, acc_ws, acc_tt} | h;
      if (cur_odd) begin
         det[7] = acc_cap;
         det[5] = acc_ws;
      end else begin
         det[6] = acc_cap;
         det[4] = acc_ws;
      end
      det[3] = acc_tt;
      {acc_cap, acc_ws, acc_tt} = 3'h0;
      cur_odd = odd;
   endtask

   task automatic found(input logic [2:0] h);
      @(posedge clk);
      {ccf, wsf, ttf} <= h;
      @(posedge clk);
      {ccf, wsf, ttf} <= 3'h0;
      {acc_cap, acc_ws, acc_tt} = {acc_cap, acc_ws, acc_tt} | h;
      #1;
      chk("host latch", {6'h0, h[2:1]}, {6'h0, cap_lat, ws_lat});
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      #2_000_000;
      failures++;
      report_and_stop();
   end

   initial begin
      {rst, wr, rd, fst, fodd, ccf, wsf, ttf, autod, stdf} = 10'h200;
      {addr, wdata, ttd, cmode, amode, lock, cps} = 35'h0;
      {cur_odd, acc_cap, acc_ws, acc_tt, ctrl, det} = 20'h0;
      void'($urandom(32'hbdc1));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rreg(8'h0b, 8'h00);
      rreg(8'h0c, 8'h00);
      rreg(8'h0e, 8'h00);
      rreg(8'h0d, 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 24; i++) begin
         ctrl = (i == 0) ? 8'hff : 8'($urandom);
         wreg(8'h0b, ctrl);
         ctrl &= 8'he1;
         cmode <= (i == 0) ? 2'h3 : 2'($urandom);
         amode <= 2'($urandom);
         {lock, cps, stdf, autod} <= 9'($urandom);
         fs((i == 0) | 1'($urandom), hit3(1'b0));
         repeat (3) found(hit3(i == 0));
         // last found hit three cycles before the field ends; the start cycle itself may carry more hits
         @(posedge clk);
         fs(1'($urandom), hit3(i == 0));
         @(posedge clk);
         ttd <= 8'($urandom);
         repeat (2) @(posedge clk);
         #1;
         chk("anc enables", {4'h0, ctrl[7] & hits(cmode, cur_odd),
             ctrl[6] & hits(amode, cur_odd), ctrl[5], ctrl[0]},
             {4'h0, cap_en, ws_en, tt_en, rt_en});
         chk("anc teletext", ctrl[5] ? ttd : 8'h00, anc_ttd);
         wreg(8'h0c, 8'($urandom));
         wreg(8'h0e, 8'($urandom));
         rreg(8'h0b, ctrl);
         rreg(8'h0c, det);
         rreg(8'h0e, vstat());
      end
      $display("test random fields done");
      report_and_stop();
   end
endmodule

`default_nettype wire
